// ---- src/radio_cfg_pkg.sv ----
// Constants, field layouts and reset values for the radio synthesizer and modem configuration bank
package radio_cfg_pkg;

	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;

	// Register indices; the bus byte address is four times the index
	localparam logic [15:0] IDX_IF_CTRL = 16'hDF07;
	localparam logic [15:0] IDX_OFFSET_CTRL = 16'hDF08;
	localparam logic [15:0] IDX_CARRIER_HIGH = 16'hDF09;
	localparam logic [15:0] IDX_CARRIER_MIDDLE = 16'hDF0A;
	localparam logic [15:0] IDX_CARRIER_LOW = 16'hDF0B;
	localparam logic [15:0] IDX_BW_RATE_EXP = 16'hDF0C;
	localparam logic [15:0] IDX_RATE_MANTISSA = 16'hDF0D;
	localparam logic [1:0] WORD_SHIFT = 2'h2;

	// intermediate_frequency_ctrl fields
	localparam int IF_WORD_LSB = 0;
	localparam int IF_WORD_W = 5;
	localparam int IF_RSVD_BIT = 5;
	localparam logic [4:0] IF_WORD_RST = 5'h0F;
	localparam logic IF_RSVD_RST = 1'h0;

	// synth_offset_ctrl
	localparam logic [7:0] OFFSET_RST = 8'h00;

	// carrier_word_high fields, plus the middle and low byte reset values and the full carrier width
	localparam int CARRIER_HIGH_W = 6;
	localparam logic [1:0] CARRIER_TOP_FIXED = 2'h1;
	localparam logic [5:0] CARRIER_HIGH_RST = 6'h1E;
	localparam logic [7:0] CARRIER_MIDDLE_RST = 8'hC4;
	localparam logic [7:0] CARRIER_LOW_RST = 8'hEC;
	localparam int CARRIER_W = 24;

	// bandwidth_rate_exponent fields
	localparam int BW_EXP_LSB = 6;
	localparam int BW_MANT_LSB = 4;
	localparam int RATE_EXP_LSB = 0;
	localparam logic [1:0] BW_EXP_RST = 2'h2;
	localparam logic [1:0] BW_MANT_RST = 2'h0;
	localparam logic [3:0] RATE_EXP_RST = 4'hC;

	// symbol_rate_mantissa_reg
	localparam logic [7:0] RATE_MANT_RST = 8'h22;

	// Scaling between frequency resolutions as shifts in carrier-word steps, then decimation and symbol rate constants
	localparam int IF_TO_CARRIER_SHIFT = 6;
	localparam int OFFSET_TO_CARRIER_SHIFT = 2;
	localparam logic [3:0] BW_BASE_MANT = 4'h4;
	localparam int BW_PRESCALE_SHIFT = 3;
	localparam int DECIM_W = 9;
	localparam logic [8:0] RATE_HIDDEN_ONE = 9'h100;
	localparam int RATE_WORD_W = 24;

endpackage

// ---- src/frequency_compose.sv ----
// Combinational arithmetic turning configuration fields into synthesizer and modem words
`timescale 1ns/1ps
`default_nettype none
module frequency_compose (
	input wire logic [4:0] ifWord,
	input wire logic [7:0] offsetWord,
	input wire logic [23:0] carrierWord,
	input wire logic rxActive,
	input wire logic [1:0] bwExponent,
	input wire logic [1:0] bwMantissa,
	input wire logic [3:0] rateExponent,
	input wire logic [7:0] rateMantissa,
	output logic [23:0] synthWord,
	output logic [8:0] decimRatio,
	output logic [23:0] rateWord
);
	logic [23:0] offsetScaled;
	logic [23:0] ifScaled;
	logic [8:0] bwFactor;
	logic [23:0] rateMant;

	// Offset step is four carrier steps, sign extended
	assign offsetScaled = {{14{offsetWord[7]}}, offsetWord, 2'h0};
	// IF step is sixty-four carrier steps
	assign ifScaled = {13'h0000, ifWord, 6'h00};
	assign synthWord = carrierWord + offsetScaled - (rxActive ? ifScaled : 24'h000000);

	assign bwFactor = {5'h00, radio_cfg_pkg::BW_BASE_MANT} + {7'h00, bwMantissa};
	assign decimRatio = 9'((bwFactor << radio_cfg_pkg::BW_PRESCALE_SHIFT) << bwExponent);

	assign rateMant = {15'h0000, radio_cfg_pkg::RATE_HIDDEN_ONE | {1'h0, rateMantissa}};
	assign rateWord = rateMant << rateExponent;
endmodule
`default_nettype wire

// ---- src/radio_synth_modem_config_regs.sv ----
// APB register bank for the radio synthesizer frequency and modem rate settings
`timescale 1ns/1ps
`default_nettype none
module radio_synth_modem_config_regs (
	input wire logic clock,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxActive,
	output logic [4:0] ifWord,
	output logic [4:0] mixerWord,
	output logic [7:0] synthOffsetWord,
	output logic [23:0] carrierWord,
	output logic [23:0] synthWord,
	output logic [1:0] filterBwExponent,
	output logic [1:0] filterBwMantissa,
	output logic [8:0] decimRatio,
	output logic [3:0] symbolRateExponent,
	output logic [7:0] symbolRateMantissa,
	output logic [23:0] symbolRateWord
);
	logic [4:0] ifWord_r;
	logic ifRsvd_r;
	logic [7:0] offset_r;
	logic [5:0] carrierHigh_r;
	logic [7:0] carrierMiddle_r;
	logic [7:0] carrierLow_r;
	logic [1:0] bwExp_r;
	logic [1:0] bwMant_r;
	logic [3:0] rateExp_r;
	logic [7:0] rateMant_r;
	logic [31:0] prdata_r;
	logic [23:0] synthWord_r;
	logic [8:0] decimRatio_r;
	logic [23:0] rateWord_r;
	logic [23:0] synthWord_nxt;
	logic [8:0] decimRatio_nxt;
	logic [23:0] rateWord_nxt;
	logic [7:0] readByte;
	logic mapped;
	logic setupPhase;
	logic accessDone;
	logic wrLow;

	// True when the bus address selects the register with the given index
	function automatic logic hitReg(input logic [31:0] addr, input logic [15:0] idx);
		hitReg = (addr == ({16'h0000, idx} << radio_cfg_pkg::WORD_SHIFT));
	endfunction

	assign mapped = hitReg(paddr, radio_cfg_pkg::IDX_IF_CTRL)
		| hitReg(paddr, radio_cfg_pkg::IDX_OFFSET_CTRL)
		| hitReg(paddr, radio_cfg_pkg::IDX_CARRIER_HIGH)
		| hitReg(paddr, radio_cfg_pkg::IDX_CARRIER_MIDDLE)
		| hitReg(paddr, radio_cfg_pkg::IDX_CARRIER_LOW)
		| hitReg(paddr, radio_cfg_pkg::IDX_BW_RATE_EXP)
		| hitReg(paddr, radio_cfg_pkg::IDX_RATE_MANTISSA);

	// Zero-wait slave; errors only on unmapped addresses
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign setupPhase = psel & ~penable;
	assign accessDone = psel & penable & pready;
	// Only the low byte lane carries register data
	assign wrLow = accessDone & pwrite & mapped & pstrb[0];

	always_ff @(posedge clock) begin
		if (srst) begin
			ifWord_r <= radio_cfg_pkg::IF_WORD_RST;
			ifRsvd_r <= radio_cfg_pkg::IF_RSVD_RST;
		end else if (wrLow && hitReg(paddr, radio_cfg_pkg::IDX_IF_CTRL)) begin
			ifWord_r <= pwdata[radio_cfg_pkg::IF_WORD_LSB +: radio_cfg_pkg::IF_WORD_W];
			ifRsvd_r <= pwdata[radio_cfg_pkg::IF_RSVD_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			offset_r <= radio_cfg_pkg::OFFSET_RST;
		end else if (wrLow && hitReg(paddr, radio_cfg_pkg::IDX_OFFSET_CTRL)) begin
			offset_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			carrierHigh_r <= radio_cfg_pkg::CARRIER_HIGH_RST;
			carrierMiddle_r <= radio_cfg_pkg::CARRIER_MIDDLE_RST;
			carrierLow_r <= radio_cfg_pkg::CARRIER_LOW_RST;
		end else if (wrLow) begin
			if (hitReg(paddr, radio_cfg_pkg::IDX_CARRIER_HIGH)) begin
				// Top two bits are fixed; only the low six are stored
				carrierHigh_r <= pwdata[radio_cfg_pkg::CARRIER_HIGH_W-1:0];
			end
			if (hitReg(paddr, radio_cfg_pkg::IDX_CARRIER_MIDDLE)) begin
				carrierMiddle_r <= pwdata[7:0];
			end
			if (hitReg(paddr, radio_cfg_pkg::IDX_CARRIER_LOW)) begin
				carrierLow_r <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			bwExp_r <= radio_cfg_pkg::BW_EXP_RST;
			bwMant_r <= radio_cfg_pkg::BW_MANT_RST;
			rateExp_r <= radio_cfg_pkg::RATE_EXP_RST;
		end else if (wrLow && hitReg(paddr, radio_cfg_pkg::IDX_BW_RATE_EXP)) begin
			bwExp_r <= pwdata[radio_cfg_pkg::BW_EXP_LSB +: 2];
			bwMant_r <= pwdata[radio_cfg_pkg::BW_MANT_LSB +: 2];
			rateExp_r <= pwdata[radio_cfg_pkg::RATE_EXP_LSB +: 4];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rateMant_r <= radio_cfg_pkg::RATE_MANT_RST;
		end else if (wrLow && hitReg(paddr, radio_cfg_pkg::IDX_RATE_MANTISSA)) begin
			rateMant_r <= pwdata[7:0];
		end
	end

	// Read mux; unused bits read as zero, the reserved IF bit reads back its stored value
	always_comb begin
		readByte = 8'h00;
		if (hitReg(paddr, radio_cfg_pkg::IDX_IF_CTRL)) begin
			readByte = {2'h0, ifRsvd_r, ifWord_r};
		end else if (hitReg(paddr, radio_cfg_pkg::IDX_OFFSET_CTRL)) begin
			readByte = offset_r;
		end else if (hitReg(paddr, radio_cfg_pkg::IDX_CARRIER_HIGH)) begin
			readByte = {radio_cfg_pkg::CARRIER_TOP_FIXED, carrierHigh_r};
		end else if (hitReg(paddr, radio_cfg_pkg::IDX_CARRIER_MIDDLE)) begin
			readByte = carrierMiddle_r;
		end else if (hitReg(paddr, radio_cfg_pkg::IDX_CARRIER_LOW)) begin
			readByte = carrierLow_r;
		end else if (hitReg(paddr, radio_cfg_pkg::IDX_BW_RATE_EXP)) begin
			readByte = {bwExp_r, bwMant_r, rateExp_r};
		end else if (hitReg(paddr, radio_cfg_pkg::IDX_RATE_MANTISSA)) begin
			readByte = rateMant_r;
		end
	end

	// Read data is captured in the setup cycle so it is stable through the access phase
	always_ff @(posedge clock) begin
		if (srst) begin
			prdata_r <= 32'h00000000;
		end else if (setupPhase) begin
			prdata_r <= {24'h000000, readByte};
		end
	end

	frequency_compose u_compose (
		.ifWord(ifWord_r),
		.offsetWord(offset_r),
		.carrierWord({radio_cfg_pkg::CARRIER_TOP_FIXED, carrierHigh_r, carrierMiddle_r, carrierLow_r}),
		.rxActive(rxActive),
		.bwExponent(bwExp_r),
		.bwMantissa(bwMant_r),
		.rateExponent(rateExp_r),
		.rateMantissa(rateMant_r),
		.synthWord(synthWord_nxt),
		.decimRatio(decimRatio_nxt),
		.rateWord(rateWord_nxt)
	);

	// Derived words are registered so downstream logic sees clean flip-flop outputs
	always_ff @(posedge clock) begin
		if (srst) begin
			synthWord_r <= 24'h000000;
			decimRatio_r <= 9'h000;
			rateWord_r <= 24'h000000;
		end else begin
			synthWord_r <= synthWord_nxt;
			decimRatio_r <= decimRatio_nxt;
			rateWord_r <= rateWord_nxt;
		end
	end

	assign prdata = prdata_r;
	assign ifWord = ifWord_r;
	assign mixerWord = ifWord_r;
	assign synthOffsetWord = offset_r;
	assign carrierWord = {radio_cfg_pkg::CARRIER_TOP_FIXED, carrierHigh_r, carrierMiddle_r, carrierLow_r};
	assign synthWord = synthWord_r;
	assign filterBwExponent = bwExp_r;
	assign filterBwMantissa = bwMant_r;
	assign decimRatio = decimRatio_r;
	assign symbolRateExponent = rateExp_r;
	assign symbolRateMantissa = rateMant_r;
	assign symbolRateWord = rateWord_r;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	sequence s_writeAt(logic [15:0] idx);
		psel && penable && pwrite && pstrb[0] && hitReg(paddr, idx);
	endsequence

	sequence s_readSetup(logic [15:0] idx);
		psel && !penable && !pwrite && hitReg(paddr, idx);
	endsequence

	property p_ifReset;
		$fell(srst) |-> (ifWord == 5'h0F) && (symbolRateExponent == 4'hC);
	endproperty
	a_ifReset: assert property (@(posedge clock) disable iff (1'b0) p_ifReset) else $error("IF or rate exponent reset wrong");

	property p_ifWrite;
		s_writeAt(radio_cfg_pkg::IDX_IF_CTRL) |=> (ifWord == $past(pwdata[4:0])) && (mixerWord == ifWord);
	endproperty
	a_ifWrite: assert property (p_ifWrite) else $error("IF word not updated by write");

	property p_rxSubtract;
		rxActive ##1 1'b1 |-> synthWord == 24'($past(carrierWord)
			+ {{14{$past(synthOffsetWord[7])}}, $past(synthOffsetWord), 2'h0}
			- {13'h0000, $past(ifWord), 6'h00});
	endproperty
	a_rxSubtract: assert property (p_rxSubtract) else $error("Receive synth word does not subtract IF");

	property p_offsetAdd;
		!rxActive ##1 1'b1 |-> synthWord == 24'($past(carrierWord)
			+ {{14{$past(synthOffsetWord[7])}}, $past(synthOffsetWord), 2'h0});
	endproperty
	a_offsetAdd: assert property (p_offsetAdd) else $error("Synth word offset wrong");

	property p_carrierMiddle;
		s_writeAt(radio_cfg_pkg::IDX_CARRIER_MIDDLE) |=> carrierWord[15:8] == $past(pwdata[7:0]);
	endproperty
	a_carrierMiddle: assert property (p_carrierMiddle) else $error("Carrier middle byte not written");

	property p_carrierLowHold;
		!wrLow |=> $stable(carrierWord[7:0]) && $stable(carrierWord[15:8]);
	endproperty
	a_carrierLowHold: assert property (p_carrierLowHold) else $error("Carrier word changed without write");

	property p_decimation;
		1'b1 ##1 1'b1 |-> decimRatio == 9'((9'h020 + {4'h0, $past(filterBwMantissa), 3'h0}) << $past(filterBwExponent));
	endproperty
	a_decimation: assert property (p_decimation) else $error("Decimation ratio wrong");

	property p_rateExpWrite;
		s_writeAt(radio_cfg_pkg::IDX_BW_RATE_EXP) |=> (symbolRateExponent == $past(pwdata[3:0]))
			##1 (symbolRateWord[23:8] != 16'h0000 || symbolRateExponent < 4'h8);
	endproperty
	a_rateExpWrite: assert property (p_rateExpWrite) else $error("Rate exponent write or use wrong");

	property p_rateWord;
		1'b1 ##1 1'b1 |-> symbolRateWord == 24'({15'h0000, 1'b1, $past(symbolRateMantissa)} << $past(symbolRateExponent));
	endproperty
	a_rateWord: assert property (p_rateWord) else $error("Symbol rate word wrong");

	property p_rateMantReset;
		$fell(srst) |-> symbolRateMantissa == 8'h22 ##1 symbolRateWord == 24'h122000;
	endproperty
	a_rateMantReset: assert property (@(posedge clock) disable iff (1'b0) p_rateMantReset) else $error("Mantissa reset wrong");

	property p_highTopRead;
		s_readSetup(radio_cfg_pkg::IDX_CARRIER_HIGH) |=> prdata[7:6] == 2'h1 && prdata[31:8] == 24'h000000;
	endproperty
	a_highTopRead: assert property (p_highTopRead) else $error("Carrier high top bits not 01");

	property p_highTopWord;
		s_writeAt(radio_cfg_pkg::IDX_CARRIER_HIGH) |=> carrierWord[23:16] == {2'h1, $past(pwdata[5:0])};
	endproperty
	a_highTopWord: assert property (p_highTopWord) else $error("Carrier high write wrong");

	// Field writes land in the cycle after the access
	property p_offsetWrite;
		s_writeAt(radio_cfg_pkg::IDX_OFFSET_CTRL) |=> synthOffsetWord == $past(pwdata[7:0]);
	endproperty
	a_offsetWrite: assert property (p_offsetWrite) else $error("Offset byte not written");

	property p_carrierLowWrite;
		s_writeAt(radio_cfg_pkg::IDX_CARRIER_LOW) |=> carrierWord[7:0] == $past(pwdata[7:0]);
	endproperty
	a_carrierLowWrite: assert property (p_carrierLowWrite) else $error("Carrier low byte not written");

	property p_bwFieldsWrite;
		s_writeAt(radio_cfg_pkg::IDX_BW_RATE_EXP) |=> (filterBwExponent == $past(pwdata[7:6]))
			&& (filterBwMantissa == $past(pwdata[5:4]));
	endproperty
	a_bwFieldsWrite: assert property (p_bwFieldsWrite) else $error("Filter fields not written");

	property p_rateMantWrite;
		s_writeAt(radio_cfg_pkg::IDX_RATE_MANTISSA) |=> symbolRateMantissa == $past(pwdata[7:0]);
	endproperty
	a_rateMantWrite: assert property (p_rateMantWrite) else $error("Rate mantissa not written");

	// Fixed bits, direct copies and reset values
	property p_carrierTop;
		carrierWord[23:22] == 2'h1;
	endproperty
	a_carrierTop: assert property (p_carrierTop) else $error("Carrier top bits not 01");

	property p_mixerFollows;
		mixerWord == ifWord;
	endproperty
	a_mixerFollows: assert property (p_mixerFollows) else $error("Mixer word differs from IF word");

	property p_carrierReset;
		$fell(srst) |-> (carrierWord == 24'h5EC4EC) && (synthOffsetWord == 8'h00);
	endproperty
	a_carrierReset: assert property (@(posedge clock) disable iff (1'b0) p_carrierReset) else $error("Carrier reset wrong");

	property p_bwReset;
		$fell(srst) |-> ((filterBwExponent == 2'h2) && (filterBwMantissa == 2'h0)) ##1 (decimRatio == 9'h080);
	endproperty
	a_bwReset: assert property (@(posedge clock) disable iff (1'b0) p_bwReset) else $error("Filter reset wrong");

	// Refused writes leave the offset, carrier, IF and symbol rate mantissa fields alone
	property p_strobeOffIgnored;
		psel && penable && pwrite && !pstrb[0] |=> $stable(synthOffsetWord) && $stable(carrierWord)
			&& $stable(ifWord) && $stable(symbolRateMantissa);
	endproperty
	a_strobeOffIgnored: assert property (p_strobeOffIgnored) else $error("Write without lane strobe landed");

	property p_unmappedIgnored;
		psel && penable && pwrite && !mapped |=> $stable(carrierWord) && $stable(synthOffsetWord)
			&& $stable(symbolRateMantissa) && $stable(ifWord);
	endproperty
	a_unmappedIgnored: assert property (p_unmappedIgnored) else $error("Unmapped write changed a field");

	property p_carrierHighHold;
		!wrLow |=> $stable(carrierWord[23:16]);
	endproperty
	a_carrierHighHold: assert property (p_carrierHighHold) else $error("Carrier high changed without write");

	property p_rateMantHold;
		!wrLow |=> $stable(symbolRateMantissa) && $stable(symbolRateExponent);
	endproperty
	a_rateMantHold: assert property (p_rateMantHold) else $error("Rate fields changed without write");

	// Read-back paths
	property p_ifReadBack;
		s_readSetup(radio_cfg_pkg::IDX_IF_CTRL) |=> (prdata[7:6] == 2'h0) && (prdata[4:0] == $past(ifWord));
	endproperty
	a_ifReadBack: assert property (p_ifReadBack) else $error("IF control read-back wrong");

	property p_rateReadBack;
		s_readSetup(radio_cfg_pkg::IDX_BW_RATE_EXP) |=> (prdata[3:0] == $past(symbolRateExponent))
			&& (prdata[7:6] == $past(filterBwExponent));
	endproperty
	a_rateReadBack: assert property (p_rateReadBack) else $error("Exponent read-back wrong");

endmodule
`default_nettype wire

// ---- testbench/radio_synth_modem_config_regs_tb.sv ----
// Self-checking bench for the radio synthesizer and modem configuration bank
`timescale 1ns/1ps
`default_nettype none
module radio_synth_modem_config_regs_tb;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic rxActive = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [4:0] ifWord;
	logic [4:0] mixerWord;
	logic [7:0] synthOffsetWord;
	logic [23:0] carrierWord;
	logic [23:0] synthWord;
	logic [1:0] filterBwExponent;
	logic [1:0] filterBwMantissa;
	logic [8:0] decimRatio;
	logic [3:0] symbolRateExponent;
	logic [7:0] symbolRateMantissa;
	logic [23:0] symbolRateWord;
	logic [31:0] rdData;
	logic errBit;
	int errorCnt = 0;
	int cmpCount = 0;
	int cycles = 0;
	int accCycles = 0;
	logic [15:0] idxTab [7] = '{radio_cfg_pkg::IDX_IF_CTRL, radio_cfg_pkg::IDX_OFFSET_CTRL,
		radio_cfg_pkg::IDX_CARRIER_HIGH, radio_cfg_pkg::IDX_CARRIER_MIDDLE, radio_cfg_pkg::IDX_CARRIER_LOW,
		radio_cfg_pkg::IDX_BW_RATE_EXP, radio_cfg_pkg::IDX_RATE_MANTISSA};
	logic [7:0] rstTab [7] = '{8'h0F, 8'h00, 8'h5E, 8'hC4, 8'hEC, 8'h8C, 8'h22};
	// Read-back after writing all ones: unused bits read 0, fixed bits read 01
	logic [7:0] onesTab [7] = '{8'h3F, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

	radio_synth_modem_config_regs dut (
		.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxActive(rxActive), .ifWord(ifWord), .mixerWord(mixerWord),
		.synthOffsetWord(synthOffsetWord), .carrierWord(carrierWord), .synthWord(synthWord),
		.filterBwExponent(filterBwExponent), .filterBwMantissa(filterBwMantissa),
		.decimRatio(decimRatio), .symbolRateExponent(symbolRateExponent),
		.symbolRateMantissa(symbolRateMantissa), .symbolRateWord(symbolRateWord)
	);

	always #50 clock = ~clock;

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			errorCnt++;
			conclude;
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			errorCnt++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] st);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {14'h0000, idx, 2'h0};
		pwdata <= {24'h000000, d};
		pstrb <= st;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1);
		accCycles = n;
		rdData = prdata;
		errBit = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic regWrite(input logic [15:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 4'h1);
		check("pslverr on write", {31'h0, errBit}, 32'h0);
		check("access cycles on write", accCycles, 32'h1);
	endtask

	task automatic regRead(input logic [15:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00, 4'h0);
		check("prdata", rdData, {24'h000000, exp});
		check("pslverr on read", {31'h0, errBit}, 32'h0);
		check("access cycles on read", accCycles, 32'h1);
	endtask

	function automatic logic [23:0] synthExp(input logic [23:0] c, input logic [7:0] o, input logic [4:0] f,
		input logic rx);
		synthExp = c + {{14{o[7]}}, o, 2'h0} - (rx ? {13'h0000, f, 6'h00} : 24'h000000);
	endfunction

	task automatic resetTable;
		for (int i = 0; i < 7; i++) begin
			regRead(idxTab[i], rstTab[i]);
		end
	endtask

	initial begin
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		resetTable();
		repeat (2) @(posedge clock);
		check("carrierWord", {8'h00, carrierWord}, 32'h005EC4EC);
		check("decimRatio", {23'h0, decimRatio}, 32'h00000080);
		check("symbolRateWord", {8'h00, symbolRateWord}, 32'h00122000);
		check("synthWord", {8'h00, synthWord}, 32'h005EC4EC);
		check("ifWord", {27'h0, ifWord}, 32'h0000000F);
		for (int i = 0; i < 7; i++) begin
			regWrite(idxTab[i], 8'hFF);
			regRead(idxTab[i], onesTab[i]);
		end
		// Write with lane 0 strobe off must not land
		apb(1'b1, idxTab[1], 8'h55, 4'hE);
		regRead(idxTab[1], 8'hFF);
		apb(1'b0, 16'hDF0E, 8'h00, 4'h0);
		check("pslverr unmapped", {31'h0, errBit}, 32'h00000001);
		check("prdata unmapped", rdData, 32'h0);
		apb(1'b1, 16'hDF06, 8'h12, 4'h1);
		check("pslverr unmapped", {31'h0, errBit}, 32'h00000001);
		regWrite(idxTab[2], 8'h10);
		regWrite(idxTab[3], 8'h00);
		regWrite(idxTab[4], 8'h00);
		regWrite(idxTab[1], 8'h80);
		regWrite(idxTab[0], 8'h1F);
		for (int r = 0; r < 2; r++) begin
			rxActive <= r[0];
			repeat (3) @(posedge clock);
			check("synthWord", {8'h00, synthWord}, {8'h00, synthExp(24'h500000, 8'h80, 5'h1F, r[0])});
			check("mixerWord", {27'h0, mixerWord}, 32'h0000001F);
		end
		regWrite(idxTab[1], 8'h7F);
		repeat (3) @(posedge clock);
		check("synthOffsetWord", {24'h0, synthOffsetWord}, 32'h0000007F);
		check("synthWord", {8'h00, synthWord}, {8'h00, synthExp(24'h500000, 8'h7F, 5'h1F, 1'b1)});
		for (int e = 0; e < 4; e++) begin
			for (int m = 0; m < 4; m++) begin
				regWrite(idxTab[5], {e[1:0], m[1:0], 4'h3});
				repeat (3) @(posedge clock);
				check("decimRatio", {23'h0, decimRatio}, 32'((8 * (4 + m)) << e));
				check("filterBw", {28'h0, filterBwExponent, filterBwMantissa}, {28'h0, e[1:0], m[1:0]});
			end
		end
		for (int e = 0; e < 16; e++) begin
			regWrite(idxTab[5], {4'h0, e[3:0]});
			repeat (3) @(posedge clock);
			check("symbolRateWord", {8'h00, symbolRateWord}, 32'(511 << e));
			check("symbolRateExponent", {28'h0, symbolRateExponent}, 32'(e));
		end
		regWrite(idxTab[6], 8'h00);
		repeat (3) @(posedge clock);
		check("symbolRateWord", {8'h00, symbolRateWord}, 32'h00800000);
		check("symbolRateMantissa", {24'h0, symbolRateMantissa}, 32'h0);
		// Second reset in mid-run restores every field
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		resetTable();
		conclude;
	end
endmodule
`default_nettype wire
